// >>> pcs_card_model.sv
// Behavioural inserted card: battery lines and data bus
`timescale 1ns/1ps
`default_nettype none
module pcs_card_model (input wire logic [1:0] cond, input wire logic oe, output logic bd1,
   output logic bd2, output logic [15:0] data, output logic ready);
   // A write in flight keeps the card busy
   assign ready = !oe;
   assign bd1 = cond != 2'h2;
   assign bd2 = cond == 2'h0;
   // Driven bus shows the inverse, so a stale read never matches
   assign data = oe ? ~{8'hC3, 6'h0, cond} : {8'hC3, 6'h0, cond};
endmodule
`default_nettype wire

// >>> pcs_card_status.sv
// Socket-side address, data and battery/status decode logic for a 16-bit card
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1: drive 26-bit card address, bit 25 MSB
// RL2: 16-bit shared data bus, bit 15 MSB
// RL3: battery memory card drives both detect lines
// RL4: decode good, weak, dead from detect lines
// RL5: I/O mode: detect one relays status change
// RL6: modem card uses detect one as ring
// RL7: detect two is audio only in I/O mode
// RL8: host audio is XOR of socket audio
// RL9: memory card holds ready low while busy
// RL10: synchronise card status inputs before decoding
module pcs_card_status (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic io_mode,
   input wire logic [pcs_pkg::PCS_ADDR_W-1:0] host_addr,
   input wire logic [pcs_pkg::PCS_DATA_W-1:0] host_wdata,
   input wire logic host_write,
   output logic [pcs_pkg::PCS_DATA_W-1:0] host_rdata,
   output logic [pcs_pkg::PCS_ADDR_W-1:0] card_addr,
   input wire logic [pcs_pkg::PCS_DATA_W-1:0] card_data_i,
   output logic [pcs_pkg::PCS_DATA_W-1:0] card_data_o,
   output logic card_data_oe,
   input wire logic battery_detect_one,
   input wire logic battery_detect_two,
   input wire logic card_ready,
   input wire logic other_audio_in,
   output logic [1:0] battery_state,
   output logic card_status_change,
   output logic ring_indicate_in,
   output logic card_ready_sync,
   output logic host_audio_out
);
   import pcs_pkg::*;

   // ****************************************
   // Synchronisers
   // ****************************************
   // Channel order: 0 detect one, 1 detect two, 2 ready, 3 socket audio
   logic [PCS_SYNC_CH-1:0] sync_in;
   logic [PCS_SYNC_CH-1:0] sync_q;
   logic det1_s;
   logic det2_s;
   logic rdy_s;
   logic aud_s;

   assign sync_in = {other_audio_in, card_ready, battery_detect_two, battery_detect_one};

   for (genvar g = 0; g < PCS_SYNC_CH; g++) begin : g_sync
      // Card lines idle high; the audio mix idles low so reset gives no tone
      localparam logic [1:0] STAGE_RST = (g == 3) ? PCS_AUDIO_SYNC_RST : PCS_SYNC_RST;
      logic [1:0] stage_r;
      logic [1:0] stage_nxt;

      always_comb begin
         // Stage 0 is read only by stage 1 (see RL10)
         stage_nxt = {stage_r[0], sync_in[g]};
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            stage_r <= STAGE_RST;
         end else begin
            stage_r <= stage_nxt;
         end
      end

      assign sync_q[g] = stage_r[1];
   end

   assign det1_s = sync_q[0];
   assign det2_s = sync_q[1];
   assign rdy_s = sync_q[2];
   assign aud_s = sync_q[3];

   // ****************************************
   // Address and write data toward the card
   // ****************************************
   logic [PCS_ADDR_W-1:0] addr_r, addr_nxt;
   logic [PCS_DATA_W-1:0] wdat_r, wdat_nxt;
   logic oe_r, oe_nxt;

   always_comb begin
      addr_nxt = host_addr;                  // see RL1
      wdat_nxt = host_wdata;                 // see RL2
      oe_nxt = host_write;                   // see RL2
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= PCS_ADDR_RST;
         wdat_r <= PCS_DATA_RST;
         oe_r <= PCS_OE_RST;
      end else begin
         addr_r <= addr_nxt;
         wdat_r <= wdat_nxt;
         oe_r <= oe_nxt;
      end
   end

   // ****************************************
   // Read data capture
   // ****************************************
   logic [PCS_DATA_W-1:0] rdat_r, rdat_nxt;

   always_comb begin
      // While we drive the bus the card lines only echo us, so hold the last read
      if (oe_r) begin
         rdat_nxt = rdat_r;
      end else begin
         rdat_nxt = card_data_i;             // see RL2
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdat_r <= PCS_DATA_RST;
      end else begin
         rdat_r <= rdat_nxt;
      end
   end

   // ****************************************
   // Battery condition decode
   // ****************************************
   pcs_batt_t batt_r, batt_nxt;

   always_comb begin
      // Detect one low wins: data is already gone, weak is moot
      if (!det1_s) begin
         batt_nxt = PCS_BATT_DEAD;           // see RL4
      end else if (!det2_s) begin
         batt_nxt = PCS_BATT_WEAK;           // see RL4
      end else begin
         batt_nxt = PCS_BATT_GOOD;           // see RL4
      end
      // The lines carry other meanings in I/O mode; report good there
      if (io_mode) begin
         batt_nxt = PCS_BATT_GOOD;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         batt_r <= PCS_BATT_RST;
      end else begin
         batt_r <= batt_nxt;
      end
   end

   // ****************************************
   // Status change and ring
   // ****************************************
   logic chg_r, chg_nxt;
   logic ring_r, ring_nxt;

   always_comb begin
      // Card signals status change and ring active low on detect one
      chg_nxt = io_mode & ~det1_s;           // see RL5
      ring_nxt = io_mode & ~det1_s;          // see RL6
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chg_r <= PCS_FLAG_RST;
         ring_r <= PCS_FLAG_RST;
      end else begin
         chg_r <= chg_nxt;
         ring_r <= ring_nxt;
      end
   end

   // ****************************************
   // Card ready
   // ****************************************
   logic rdy_o_r, rdy_o_nxt;

   always_comb begin
      rdy_o_nxt = rdy_s;                     // see RL9
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_o_r <= PCS_READY_RST;
      end else begin
         rdy_o_r <= rdy_o_nxt;
      end
   end

   // ****************************************
   // Speaker mix
   // ****************************************
   logic spk_r, spk_nxt;

   always_comb begin
      // Audio from this socket counts only in I/O mode
      spk_nxt = (io_mode & det2_s) ^ aud_s;  // see RL7 see RL8
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         spk_r <= PCS_AUDIO_RST;
      end else begin
         spk_r <= spk_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   assign card_addr = addr_r;
   assign card_data_o = wdat_r;
   assign card_data_oe = oe_r;
   assign host_rdata = rdat_r;
   assign battery_state = batt_r;
   assign card_status_change = chg_r;
   assign ring_indicate_in = ring_r;
   assign card_ready_sync = rdy_o_r;
   assign host_audio_out = spk_r;
endmodule

`default_nettype wire

// >>> pcs_card_status_properties.sv
// Port checker for the card status block
`timescale 1ns/1ps
`default_nettype none
module pcs_chk (input wire logic ref_clk, rst_n, io_mode, host_write, card_data_oe,
   battery_detect_one, battery_detect_two, other_audio_in, card_status_change, host_audio_out,
   input wire logic [25:0] host_addr, card_addr, input wire logic [1:0] battery_state);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_addr_follow: assert property (1 |=> card_addr == $past(host_addr)) else $error("a");
   chk_drive_dir: assert property (host_write |=> card_data_oe) else $error("oe");
   chk_batt_dead: assert property ((!battery_detect_one && !io_mode)[*3] |=>
      battery_state == 2'h2) else $error("dead");
   chk_batt_weak: assert property ((battery_detect_one && !battery_detect_two && !io_mode)[*3]
      |=> battery_state == 2'h1) else $error("weak");
   chk_io_good: assert property (io_mode |=> battery_state == 2'h0) else $error("io");
   chk_status_up: assert property ((!battery_detect_one && io_mode)[*3] |=>
      card_status_change) else $error("sc");
   chk_status_down: assert property (battery_detect_one[*3] |=> !card_status_change)
      else $error("sc0");
   chk_audio_mix: assert property ($stable({io_mode, battery_detect_two, other_audio_in})[*3]
      |=> host_audio_out == $past((io_mode & battery_detect_two) ^ other_audio_in)) else $error("au");
endmodule
bind pcs_card_status pcs_chk chk_i (.*);
`default_nettype wire

// >>> pcs_pkg.sv
// Package of constants and types for the 16-bit card status decode block
package pcs_pkg;
   localparam int PCS_ADDR_W = 26;
   localparam int PCS_DATA_W = 16;
   localparam int PCS_SYNC_STAGES = 2;
   // Battery condition codes
   typedef enum logic [1:0] {
      PCS_BATT_GOOD = 2'h0,
      PCS_BATT_WEAK = 2'h1,
      PCS_BATT_DEAD = 2'h2
   } pcs_batt_t;
   localparam logic [PCS_ADDR_W-1:0] PCS_ADDR_RST = 26'h0000000;
   localparam logic [PCS_DATA_W-1:0] PCS_DATA_RST = 16'h0000;
   localparam logic [1:0] PCS_SYNC_RST = 2'h3;
   localparam pcs_batt_t PCS_BATT_RST = PCS_BATT_GOOD;
   localparam logic [1:0] PCS_AUDIO_SYNC_RST = 2'h0;
   localparam logic PCS_OE_RST = 1'b0;
   localparam logic PCS_FLAG_RST = 1'b0;
   localparam logic PCS_READY_RST = 1'b1;
   localparam logic PCS_AUDIO_RST = 1'b0;
   localparam int PCS_SYNC_CH = 4;
endpackage

// >>> testbench.sv
// Self-checking bench for the card status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 0, rst_n = 0, io_mode = 0, host_write = 0, oth = 0, oe, bd1, bd2, sc, ri, aud;
   logic io, w, rdy, crdy;
   logic [25:0] host_addr = 0, ca;
   logic [15:0] host_wdata = 0, rdata, cdi, cdo;
   logic [1:0] cond = 0, c, bs;
   logic [63:0] r;
   logic [48:0] q[$];
   event got;
   int failures = 0, checks = 0, cyc = 0;
   always #2.5 ref_clk = ~ref_clk;
   pcs_card_model card (.cond(cond), .oe(oe), .bd1(bd1), .bd2(bd2), .data(cdi), .ready(crdy));
   pcs_card_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .io_mode(io_mode), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_write(host_write), .host_rdata(rdata), .card_addr(ca),
      .card_data_i(cdi), .card_data_o(cdo), .card_data_oe(oe), .battery_detect_one(bd1),
      .battery_detect_two(bd2), .card_ready(crdy), .other_audio_in(oth), .battery_state(bs),
      .card_status_change(sc), .ring_indicate_in(ri), .card_ready_sync(rdy), .host_audio_out(aud));
   task automatic chk(input logic [48:0] seen, input logic [48:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED =="); else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge ref_clk) if (++cyc > 500) begin
      failures++;
      wrap_up();
   end
   always @(got) chk({rdy, bs, sc, ri, aud, oe, ca, oe ? cdo : rdata}, q.pop_front());
   initial begin
      void'($urandom(23996));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1;
      // Every battery code under both interface modes, with and without a write
      for (int i = 0; i < 12; i++) begin
         @(posedge ref_clk);
         r = {$urandom, $urandom};
         {c, io, w} = {2'(i / 4), i[1], i[0]};
         {cond, io_mode, host_write, oth} <= {c, io, w, r[42]};
         {host_addr, host_wdata} <= r[41:0];
         repeat (4) @(posedge ref_clk);
         #1;
         q.push_back({!w, io ? 2'h0 : c, {2{io && c == 2'h2}}, (io && c == 2'h0) ^ r[42], w,
            r[41:16], w ? r[15:0] : {8'hC3, 6'h0, c}});
         ->got;
         #1 $display("test %0d done", i);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
